// ===== shared/pbts_params.svh
// Constants for the burst trigger sequencer: timing counts and reset values.
// Assumes a 20 MHz core clock; included by the design.
`ifndef PBTS_PARAMS_SVH
`define PBTS_PARAMS_SVH

`define PBTS_CLK_MHZ          20
`define PBTS_PERIOD_MS        80
`define PBTS_SLOT_TIME_US     1330
`define PBTS_SLOTS_PER_PERIOD 60
// Slot length in core cycles, exact product of slot time in us and clock in MHz
`define PBTS_SLOT_CYCLES      (`PBTS_SLOT_TIME_US * `PBTS_CLK_MHZ)
`define PBTS_CODE_MAX         13'h1fff
`define PBTS_COUNT_MIN        31'h0000_0001
`define PBTS_COUNT_MAX        31'h7fff_741c
`define PBTS_CODE_RST         13'h0000
`define PBTS_COUNT_RST        31'h0000_0001
`define PBTS_MASK_RST         60'h000_0000_0000_0001

`endif

// ===== shared/pbts_pkg.sv
// Types shared by the burst trigger sequencer.
// Assumes pbts_params.svh is on the include path.
`default_nettype none
package pbts_pkg;
   typedef enum logic [1:0] {
      PBTS_IDLE,
      PBTS_WAIT,
      PBTS_RUN
   } pbts_state_type;
endpackage : pbts_pkg
`default_nettype wire

// ===== design/pbts_sequencer.sv
// Burst trigger sequencer: 79.8 ms periods of 60 access slots, start
// source, repetition count, apply staging, rear pulse and leveling control.
// Assumes all inputs synchronous to core_clk_in; triggers are 1-cycle pulses.
//
// Behaviour
// - Scrambling code 0..8191 used for preamble and message of each burst.
// - One code register serves both preamble and message portions.
// - Finite count 1..2147447836 periods, or unlimited.
// - Unlimited: after trigger, run until RF, modulation or format is off.
// - Count limits transmission only with triggered start source.
// - Edits stay pending with apply-needed shown until apply.
// - Triggered: after count periods, stop, drop trigger-active, wait.
// - Each manual trigger while waiting sends the count again.
// - External trigger starts a triggered run like the manual one.
// - Immediate source: transmit as soon as format is on, or at once.
// - Manual trigger enabled only while triggered source selected.
// - Rear output one pulses at each burst start when selected.
// - One common code setup for all eight simulated user equipments.
// - Multiple-burst mode switches the output leveling loop off.
// - Each period is 60 slots 0..59, sent whole unless RF, modulation or format goes off.
// - Access slot timed as 1.33 ms.
`include "pbts_params.svh"
`default_nettype none
module pbts_sequencer import pbts_pkg::*; #(
   parameter int SLOT_CYCLES = `PBTS_SLOT_CYCLES,
   parameter int SLOTS       = `PBTS_SLOTS_PER_PERIOD
) (
   input  wire logic        core_clk_in,
   input  wire logic        rstn_in,
   input  wire logic        clk_en_in,
   input  wire logic [12:0] scramble_code_in,
   input  wire logic [30:0] period_count_in,
   input  wire logic        count_unlimited_in,
   input  wire logic [59:0] slot_mask_in,
   input  wire logic        apply_in,
   input  wire logic        trigger_source_in,
   input  wire logic        manual_trigger_in,
   input  wire logic        ext_trigger_in,
   input  wire logic        rf_on_in,
   input  wire logic        mod_on_in,
   input  wire logic        format_on_in,
   input  wire logic        multi_burst_mode_in,
   input  wire logic        burst_pulse_output_select_in,
   output logic [12:0]      scramble_code_out,
   output logic             apply_needed_out,
   output logic             transmit_out,
   output logic [5:0]       slot_index_out,
   output logic             trigger_active_indicator_out,
   output logic             manual_trigger_enable_out,
   output logic             rear_event_output_one_out,
   output logic             output_leveling_loop_en_out
);
   localparam int SCW = $clog2(SLOT_CYCLES);

   // Clamp an edited count into the legal finite range
   function automatic logic [30:0] clamp_count(input logic [30:0] c);
      if (c < `PBTS_COUNT_MIN)
         return `PBTS_COUNT_MIN;
      else if (c > `PBTS_COUNT_MAX)
         return `PBTS_COUNT_MAX;
      else
         return c;
   endfunction : clamp_count

   // Applied configuration and panel-facing flags
   logic [12:0]    code_r, code_nxt;
   logic [30:0]    cnt_r, cnt_nxt;
   logic           unlim_r, unlim_nxt;
   logic [59:0]    mask_r, mask_nxt;
   logic           need_r, need_nxt;
   logic           man_en_r, man_en_nxt;
   logic           lvl_r, lvl_nxt;
   // Sequencer state
   pbts_state_type state_r, state_nxt;
   logic [SCW-1:0] scnt_r, scnt_nxt;
   logic [5:0]     sidx_r, sidx_nxt;
   logic [30:0]    left_r, left_nxt;
   logic           src_r, src_nxt;
   logic           rear_r, rear_nxt;

   logic enabled, trig_evt, slot_end, period_end, src_rise;

   // Staged config: edits only reach the signal on apply; one set for all UEs
   always_comb begin
      code_nxt   = code_r;
      cnt_nxt    = cnt_r;
      unlim_nxt  = unlim_r;
      mask_nxt   = mask_r;
      if (apply_in) begin
         code_nxt  = scramble_code_in;
         cnt_nxt   = clamp_count(period_count_in);
         unlim_nxt = count_unlimited_in;
         mask_nxt  = slot_mask_in;
      end
      need_nxt   = (code_nxt != scramble_code_in) ||
                   (cnt_nxt != clamp_count(period_count_in)) ||
                   (unlim_nxt != count_unlimited_in) ||
                   (mask_nxt != slot_mask_in);
      man_en_nxt = trigger_source_in;
      lvl_nxt    = !multi_burst_mode_in;
   end

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         code_r   <= `PBTS_CODE_RST;
         cnt_r    <= `PBTS_COUNT_RST;
         unlim_r  <= 1'b0;
         mask_r   <= `PBTS_MASK_RST;
         need_r   <= 1'b0;
         man_en_r <= 1'b0;
         lvl_r    <= 1'b1;
      end else if (clk_en_in) begin
         code_r   <= code_nxt;
         cnt_r    <= cnt_nxt;
         unlim_r  <= unlim_nxt;
         mask_r   <= mask_nxt;
         need_r   <= need_nxt;
         man_en_r <= man_en_nxt;
         lvl_r    <= lvl_nxt;
      end
   end

   assign enabled    = rf_on_in && mod_on_in && format_on_in;
   // Manual trigger is only honoured while the triggered source is chosen
   assign trig_evt   = trigger_source_in &&
                       ((manual_trigger_in && man_en_r) || ext_trigger_in);
   assign slot_end   = scnt_r == SCW'(SLOT_CYCLES - 1);
   assign period_end = slot_end && sidx_r == 6'(SLOTS - 1);
   assign src_rise   = trigger_source_in && !src_r;

   // Period sequencer; a counted run ends on a period boundary, disable stops a run at once
   always_comb begin
      state_nxt = state_r;
      scnt_nxt  = scnt_r;
      sidx_nxt  = sidx_r;
      left_nxt  = left_r;
      src_nxt   = trigger_source_in;
      rear_nxt  = 1'b0;
      if (!enabled) begin
         state_nxt = PBTS_IDLE;
         scnt_nxt  = '0;
         sidx_nxt  = '0;
      end else begin
         unique case (state_r)
            PBTS_IDLE, PBTS_WAIT: begin
               scnt_nxt = '0;
               sidx_nxt = '0;
               if (!trigger_source_in) begin
                  state_nxt = PBTS_RUN;
               end else if (trig_evt) begin
                  state_nxt = PBTS_RUN;
                  left_nxt  = cnt_r;
               end else begin
                  state_nxt = PBTS_WAIT;
               end
            end
            PBTS_RUN: begin
               // Slot timing; whole period sent unless disabled
               rear_nxt = burst_pulse_output_select_in && scnt_r == '0 &&
                          mask_r[sidx_r];
               scnt_nxt = slot_end ? '0 : scnt_r + SCW'(1);
               if (slot_end)
                  sidx_nxt = period_end ? '0 : sidx_r + 6'h01;
               if (src_rise) begin
                  left_nxt = cnt_r;
               end else if (period_end && trigger_source_in &&
                            !unlim_r) begin
                  if (left_r == 31'h0000_0001)
                     state_nxt = PBTS_WAIT;
                  else
                     left_nxt = left_r - 31'h0000_0001;
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         state_r <= PBTS_IDLE;
         scnt_r  <= '0;
         sidx_r  <= '0;
         left_r  <= `PBTS_COUNT_RST;
         src_r   <= 1'b0;
         rear_r  <= 1'b0;
      end else if (clk_en_in) begin
         state_r <= state_nxt;
         scnt_r  <= scnt_nxt;
         sidx_r  <= sidx_nxt;
         left_r  <= left_nxt;
         src_r   <= src_nxt;
         rear_r  <= rear_nxt;
      end
   end

   // Outputs; the code drives preamble and message spreading alike
   assign scramble_code_out            = code_r;
   assign apply_needed_out             = need_r;
   assign transmit_out                 = state_r == PBTS_RUN;
   assign slot_index_out               = sidx_r;
   assign trigger_active_indicator_out = state_r == PBTS_RUN && src_r;
   assign manual_trigger_enable_out    = man_en_r;
   assign rear_event_output_one_out    = rear_r;
   assign output_leveling_loop_en_out  = lvl_r;

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rstn_in);

   sequence s_last_finite_period;
      clk_en_in && enabled && state_r == PBTS_RUN && trigger_source_in &&
      !src_rise && !unlim_r && period_end && left_r == 31'h0000_0001;
   endsequence
   sequence s_trigger_taken;
      clk_en_in && enabled && state_r == PBTS_WAIT && trig_evt;
   endsequence

   chk_apply_holds_code: assert property (
      clk_en_in && !apply_in |=> $stable(scramble_code_out))
      else $error("code changed without apply");
   chk_apply_takes_code: assert property (
      clk_en_in && apply_in |=>
         scramble_code_out == $past(scramble_code_in) && !apply_needed_out)
      else $error("apply did not take code");
   chk_unlimited_keeps: assert property (
      clk_en_in && enabled && state_r == PBTS_RUN && unlim_r |=>
         transmit_out)
      else $error("unlimited run stopped");
   chk_immediate_nolimit: assert property (
      clk_en_in && enabled && !trigger_source_in && state_r == PBTS_RUN
      |=> transmit_out)
      else $error("immediate run stopped");
   chk_count_ends_run: assert property (
      s_last_finite_period |=>
         state_r == PBTS_WAIT && !trigger_active_indicator_out)
      else $error("run did not stop after count");
   chk_trigger_reloads: assert property (
      s_trigger_taken |=> transmit_out && left_r == $past(cnt_r))
      else $error("trigger did not start or reload");
   chk_immediate_start: assert property (
      clk_en_in && enabled && !trigger_source_in |=> transmit_out)
      else $error("immediate source did not start");
   chk_manual_gate: assert property (
      clk_en_in && !trigger_source_in |=> !manual_trigger_enable_out)
      else $error("manual trigger enabled in immediate");
   chk_rear_pulse: assert property (
      rear_event_output_one_out && $past(clk_en_in) |->
         $past(scnt_r == '0) &&
         $past(state_r == PBTS_RUN) &&
         $past(burst_pulse_output_select_in))
      else $error("rear pulse not at burst start");
   chk_leveling_off: assert property (
      clk_en_in && multi_burst_mode_in |=> !output_leveling_loop_en_out)
      else $error("leveling loop left on");
   chk_period_wrap: assert property (
      clk_en_in && enabled && state_r == PBTS_RUN && period_end
      && !trigger_source_in |=> slot_index_out == 6'h00 && scnt_r == '0)
      else $error("period did not wrap after slot 59");
endmodule : pbts_sequencer
`default_nettype wire

// ===== sim/pbts_trig_src.sv
// Trigger source model: manual key and external trigger line.
// Assumes fire_in is driven just after a rising edge of core_clk_in.
`default_nettype none
module pbts_trig_src (
   input  wire logic core_clk_in,
   input  wire logic fire_in,
   input  wire logic use_ext_in,
   output logic      manual_out,
   output logic      ext_out
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      manual_out = 1'b0;
      ext_out    = 1'b0;
   end
   // One-cycle pulse on the chosen line; released lines return low
   always @(posedge core_clk_in) begin
      manual_out <= fire_in & ~use_ext_in;
      ext_out    <= fire_in & use_ext_in;
   end
endmodule : pbts_trig_src
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking bench for the burst trigger sequencer.
// Assumes a short slot length parameter so whole runs stay brief.
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int SC = 4;
   localparam int PER = 60 * SC; // Cycles in one whole period
   logic clk = 1'b0, rstn = 1'b0, fire = 1'b0, use_ext = 1'b0;
   // Triggered source from the start, so nothing runs before the trigger
   logic apply = 1'b0, src = 1'b1, unl = 1'b0, on = 1'b1, mb = 1'b0;
   logic sel = 1'b1, fmt = 1'b1;
   logic [12:0] code_in = 13'h0000;
   logic [30:0] cnt_in = 31'h0000_0001;
   logic [12:0] code_out;
   logic [5:0]  slot;
   logic need, tx, act, men, rear, lvl, mtrig, etrig;
   int n_errors = 0, comparisons = 0, len, pulses;
   always #25 clk = ~clk;
   pbts_trig_src i_pbts_trig_src (.core_clk_in(clk), .fire_in(fire),
      .use_ext_in(use_ext), .manual_out(mtrig), .ext_out(etrig));
   pbts_sequencer #(.SLOT_CYCLES(SC), .SLOTS(60)) i_pbts_sequencer (
      .core_clk_in(clk), .rstn_in(rstn), .clk_en_in(1'b1),
      .scramble_code_in(code_in), .period_count_in(cnt_in),
      .count_unlimited_in(unl), .slot_mask_in(60'h000_0000_0000_0001),
      .apply_in(apply), .trigger_source_in(src),
      .manual_trigger_in(mtrig), .ext_trigger_in(etrig),
      .rf_on_in(on), .mod_on_in(1'b1), .format_on_in(fmt),
      .multi_burst_mode_in(mb), .burst_pulse_output_select_in(sel),
      .scramble_code_out(code_out), .apply_needed_out(need),
      .transmit_out(tx), .slot_index_out(slot),
      .trigger_active_indicator_out(act),
      .manual_trigger_enable_out(men), .rear_event_output_one_out(rear),
      .output_leveling_loop_en_out(lvl));
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("FAIL %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   // Drive one-cycle pulses at the rising edge
   task automatic do_apply;
      @(posedge clk) apply <= 1'b1;
      @(posedge clk) apply <= 1'b0;
      @(negedge clk);
   endtask : do_apply
   task automatic trigger(input logic ext);
      @(posedge clk) begin
         fire    <= 1'b1;
         use_ext <= ext;
      end
      @(posedge clk) fire <= 1'b0;
   endtask : trigger
   // Bounded wait for a run, then its length and rear pulses
   task automatic measure(input int limit);
      int i;
      len = 0;
      pulses = 0;
      for (i = 0; i < 40 && tx !== 1'b1; i++) @(negedge clk);
      if (tx !== 1'b1) begin
         n_errors++;
         $display("FAIL transmit start expected 1 seen %b", tx);
         report_and_stop();
      end
      while (tx === 1'b1 && len < limit) begin
         if (rear === 1'b1) pulses++;
         len++;
         @(negedge clk);
      end
   endtask : measure
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      @(negedge clk);
      check("code", code_out, 0);
      check("apply_needed", need, 0);
      check("transmit", tx, 0);
      check("slot", slot, 0);
      check("leveling", lvl, 1);
      check("manual_enable", men, 0);
      $display("test reset done");
      @(posedge clk) begin
         code_in <= 13'h1fff;
         cnt_in  <= 31'h0000_0002;
         mb      <= 1'b1;
      end
      repeat (2) @(negedge clk);
      check("apply_needed", need, 1);
      check("code held", code_out, 0);
      check("leveling", lvl, 0);
      do_apply();
      check("code", code_out, 32'h0000_1fff);
      check("apply_needed", need, 0);
      $display("test apply done");
      @(posedge clk) src <= 1'b1;
      repeat (3) @(negedge clk);
      check("manual_enable", men, 1);
      check("no start", tx, 0);
      trigger(1'b0);
      measure(2000);
      check("run length", len, 2 * PER);
      check("rear pulses", pulses, 2);
      check("active", act, 0);
      // Pulse routing off: the external run must give no rear pulses
      @(posedge clk) sel <= 1'b0;
      repeat (2) @(negedge clk);
      trigger(1'b1);
      measure(2000);
      check("ext length", len, 2 * PER);
      check("ext pulses", pulses, 0);
      $display("test triggered done");
      @(posedge clk) begin
         unl <= 1'b1;
         sel <= 1'b1;
      end
      do_apply();
      trigger(1'b0);
      measure(3 * PER);
      check("unlimited", len, 3 * PER);
      check("unlimited pulses", pulses, 3);
      // Seven whole slots on from a period boundary
      repeat (7 * SC + 1) @(negedge clk);
      check("slot", slot, 7);
      check("active", act, 1);
      @(posedge clk) on <= 1'b0;
      repeat (3) @(negedge clk);
      check("rf off", tx, 0);
      $display("test unlimited done");
      @(posedge clk) begin
         on  <= 1'b1;
         unl <= 1'b0;
         src <= 1'b0;
         mb  <= 1'b0;
      end
      do_apply();
      measure(3 * PER);
      check("immediate", len, 3 * PER);
      check("manual_enable", men, 0);
      check("leveling", lvl, 1);
      @(posedge clk) fmt <= 1'b0;
      repeat (3) @(negedge clk);
      check("format off", tx, 0);
      @(posedge clk) fmt <= 1'b1;
      repeat (2) @(negedge clk);
      check("format on start", tx, 1);
      $display("test immediate done");
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
